// file: rtl/fbd_regs.vh
`ifndef FBD_REGS_VH
`define FBD_REGS_VH
// leading nibble patterns (first five nibbles; 7x groups use first byte)
`define FBD_PAT_MULS    20'h01c05
`define FBD_PAT_DIVS    20'h01d05
`define FBD_PAT_CRLD    20'h01406
`define FBD_PAT_WLOG    20'h01f06
`define FBD_PFX_BREG_T  8'h7c
`define FBD_PFX_BREG_M  8'h7d
`define FBD_PFX_BABS_T  8'h7e
`define FBD_PFX_BABS_M  8'h7f
`define FBD_NIB_6       4'h6
`define FBD_NIB_7       4'h7
// operation codes on the op_code output
`define FBD_OP_NONE     5'h00
`define FBD_OP_MULS     5'h01
`define FBD_OP_DIVS     5'h02
`define FBD_OP_CRLD     5'h03
`define FBD_OP_WOR      5'h04
`define FBD_OP_WXOR     5'h05
`define FBD_OP_WAND     5'h06
`define FBD_OP_TEST     5'h07
`define FBD_OP_BIT_OR   5'h08
`define FBD_OP_BIT_XOR  5'h09
`define FBD_OP_BIT_AND  5'h0a
`define FBD_OP_LOAD     5'h0b
`define FBD_OP_SET      5'h0c
`define FBD_OP_INVERT   5'h0d
`define FBD_OP_CLEAR    5'h0e
`define FBD_OP_STORE    5'h0f
// per-cycle state costs
`define FBD_S_FETCH     4'h2
`define FBD_S_INTERNAL  4'h1
`define FBD_S_PERI_FAST 4'h2
`define FBD_S_PERI_SLOW 4'h3
`endif

// file: rtl/fbd_term.v
`timescale 1ns/1ps
// one product term of the state sum: count times per-cycle cost
module fbd_term #(
  parameter CW = 8,
  parameter SW = 4,
  parameter PW = 12
) (
  input  wire [CW-1:0] count,
  input  wire [SW-1:0] cost,
  output wire [PW-1:0] product
);
  wire [CW+SW-1:0] full;
  assign full    = count * cost;
  assign product = full[PW-1:0];
endmodule

// file: rtl/fbd_decode.v
// Operation
// (RQ1) 01C05 multiply, 01D05 divide; fourth-byte high nibble picks variant
// (RQ2) high nibble msb picks alternate; 01406 control load, 01F06 word logic
// (RQ3) 7C/7D: nibble after prefix is register field; bit ops decoded
// (RQ4) 7E/7F: byte after prefix is absolute address; same bit ops
// (RQ5) execution states equal sum of each cycle count times its cost
// (RQ6) each instruction carries fixed counts for the six cycle types
// (RQ7) fetch from on-chip memory costs 2 states, internal operation 1
// (RQ8) byte access to on-chip peripheral costs 2 or 3 states by module
`timescale 1ns/1ps
`include "fbd_regs.vh"
module fbd_decode #(
  parameter CW = 8,
  parameter SW = 4,
  parameter TW = 12
) (
  input  wire          mclk,
  input  wire          reset_n,
  input  wire          instr_valid,
  input  wire [31:0]   instr_code,
  input  wire [CW-1:0] cnt_fetch,
  input  wire [CW-1:0] cnt_branch,
  input  wire [CW-1:0] cnt_stack,
  input  wire [CW-1:0] cnt_byte,
  input  wire [CW-1:0] cnt_word,
  input  wire [CW-1:0] cnt_internal,
  input  wire [SW-1:0] cost_branch,
  input  wire [SW-1:0] cost_stack,
  input  wire [SW-1:0] cost_word,
  input  wire          byte_to_peri,
  input  wire          peri_slow,
  input  wire [SW-1:0] cost_byte_mem,
  output reg           dec_valid,
  output reg  [4:0]    op_code,
  output reg           op_illegal,
  output reg  [3:0]    reg_field,
  output reg  [7:0]    abs_addr,
  output reg           uses_reg,
  output reg           uses_abs,
  output reg  [TW-1:0] exec_states
);
  wire [19:0] lead5;
  wire [7:0]  pfx;
  wire [3:0]  nib2;
  wire [3:0]  nib3;
  wire [3:0]  fourth_byte_high_nibble;
  wire [3:0]  nib5;
  wire        alt_sel;
  wire        low_var;
  assign lead5 = instr_code[31:12];
  assign pfx   = instr_code[31:24];
  assign nib2  = instr_code[23:20];
  assign nib3  = instr_code[19:16];
  // fifth nibble is the third byte's high half, last of the group pattern
  assign nib5  = instr_code[15:12];
  assign fourth_byte_high_nibble = instr_code[7:4];
  assign alt_sel = fourth_byte_high_nibble[3]; // [RQ2]
  // multiply and divide only exist in variant columns 0 to 3
  assign low_var = ~fourth_byte_high_nibble[3] & ~fourth_byte_high_nibble[2];

  reg [4:0] op_next;
  reg       breg_next;
  reg       babs_next;
  reg [3:0] bsub;
  reg       bkind_t;
  reg       is_bit;
  reg       sfx6;

  always @*
  begin
    op_next   = `FBD_OP_NONE;
    breg_next = 1'b0;
    babs_next = 1'b0;
    bsub      = 4'h0;
    bkind_t   = 1'b0;
    is_bit    = 1'b0;
    sfx6      = 1'b0;
    // four-byte group by five leading nibbles
    if (lead5 == `FBD_PAT_MULS)
    begin
      if (low_var && !fourth_byte_high_nibble[0]) // [RQ1]
        op_next = `FBD_OP_MULS;
    end
    else if (lead5 == `FBD_PAT_DIVS)
    begin
      if (low_var && fourth_byte_high_nibble[0]) // [RQ1]
        op_next = `FBD_OP_DIVS;
    end
    else if (lead5 == `FBD_PAT_CRLD)
    begin
      if (alt_sel && fourth_byte_high_nibble[0] == 1'b0) // [RQ2]
        op_next = `FBD_OP_CRLD;
    end
    else if (lead5 == `FBD_PAT_WLOG)
    begin
      case (fourth_byte_high_nibble) // [RQ2]
        4'h4: op_next = `FBD_OP_WOR;
        4'h5: op_next = `FBD_OP_WXOR;
        4'h6: op_next = `FBD_OP_WAND;
        default: op_next = `FBD_OP_NONE;
      endcase
    end
    else if (pfx == `FBD_PFX_BREG_T || pfx == `FBD_PFX_BREG_M)
    begin
      // register form: fourth nibble fixed zero, fifth nibble is 6 or 7
      if (nib3 == 4'h0 && (nib5 == `FBD_NIB_6 || nib5 == `FBD_NIB_7))
      begin
        is_bit    = 1'b1; // [RQ3]
        breg_next = 1'b1;
        bkind_t   = (pfx == `FBD_PFX_BREG_T);
        sfx6      = (nib5 == `FBD_NIB_6);
      end
    end
    else if (pfx == `FBD_PFX_BABS_T || pfx == `FBD_PFX_BABS_M)
    begin
      if (nib5 == `FBD_NIB_6 || nib5 == `FBD_NIB_7)
      begin
        is_bit    = 1'b1; // [RQ4]
        babs_next = 1'b1;
        bkind_t   = (pfx == `FBD_PFX_BABS_T);
        sfx6      = (nib5 == `FBD_NIB_6);
      end
    end
    if (is_bit)
    begin
      bsub = fourth_byte_high_nibble;
      if (bkind_t)
      begin
        // test/logic/load group; suffix 6 carries only test
        case (bsub)
          4'h3: op_next = `FBD_OP_TEST;
          4'h4: op_next = sfx6 ? `FBD_OP_NONE : `FBD_OP_BIT_OR;
          4'h5: op_next = sfx6 ? `FBD_OP_NONE : `FBD_OP_BIT_XOR;
          4'h6: op_next = sfx6 ? `FBD_OP_NONE : `FBD_OP_BIT_AND;
          4'h7: op_next = sfx6 ? `FBD_OP_NONE : `FBD_OP_LOAD;
          default: op_next = `FBD_OP_NONE;
        endcase
      end
      else
      begin
        // set/invert/clear group; store only with suffix 6
        case (bsub)
          4'h0: op_next = `FBD_OP_SET;
          4'h1: op_next = `FBD_OP_INVERT;
          4'h2: op_next = `FBD_OP_CLEAR;
          4'h7: op_next = sfx6 ? `FBD_OP_STORE : `FBD_OP_NONE;
          default: op_next = `FBD_OP_NONE;
        endcase
      end
    end
  end

  // byte access cost: peripheral cost picked by the addressed module
  wire [SW-1:0] cost_byte;
  assign cost_byte = byte_to_peri ?
                     (peri_slow ? `FBD_S_PERI_SLOW : `FBD_S_PERI_FAST) :
                     cost_byte_mem; // [RQ8]

  wire [CW-1:0] cnts  [0:5];
  wire [SW-1:0] costs [0:5];
  wire [TW-1:0] prods [0:5];
  assign cnts[0]  = cnt_fetch; // [RQ6]
  assign cnts[1]  = cnt_branch;
  assign cnts[2]  = cnt_stack;
  assign cnts[3]  = cnt_byte;
  assign cnts[4]  = cnt_word;
  assign cnts[5]  = cnt_internal;
  assign costs[0] = `FBD_S_FETCH; // [RQ7]
  assign costs[1] = cost_branch;
  assign costs[2] = cost_stack;
  assign costs[3] = cost_byte;
  assign costs[4] = cost_word;
  assign costs[5] = `FBD_S_INTERNAL; // [RQ7]

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_term
      fbd_term #(
        .CW      (CW),
        .SW      (SW),
        .PW      (TW)
      ) u_term (
        .count   (cnts[g]),
        .cost    (costs[g]),
        .product (prods[g])
      );
    end
  endgenerate

  // sum wraps at TW bits; default width covers all realistic counts
  wire [TW-1:0] total_next;
  assign total_next = prods[0] + prods[1] + prods[2] +
                      prods[3] + prods[4] + prods[5]; // [RQ5]

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dec_valid   <= 1'b0;
      op_code     <= `FBD_OP_NONE;
      op_illegal  <= 1'b0;
      reg_field   <= 4'h0;
      abs_addr    <= 8'h00;
      uses_reg    <= 1'b0;
      uses_abs    <= 1'b0;
      exec_states <= {TW{1'b0}};
    end
    else
    begin
      dec_valid <= instr_valid;
      if (instr_valid)
      begin
        op_code     <= op_next;
        op_illegal  <= (op_next == `FBD_OP_NONE);
        reg_field   <= breg_next ? nib2 : 4'h0; // [RQ3]
        abs_addr    <= babs_next ? instr_code[23:16] : 8'h00; // [RQ4]
        uses_reg    <= breg_next;
        uses_abs    <= babs_next;
        exec_states <= total_next; // [RQ5]
      end
    end
  end
endmodule

// file: verif/fbd_decode_properties.sv
`timescale 1ns/1ps
module fbd_decode_properties #(
  parameter CW = 8,
  parameter SW = 4,
  parameter TW = 12
) (
  input wire          mclk,
  input wire          reset_n,
  input wire          instr_valid,
  input wire [31:0]   instr_code,
  input wire [CW-1:0] cnt_fetch,
  input wire [CW-1:0] cnt_branch,
  input wire [CW-1:0] cnt_stack,
  input wire [CW-1:0] cnt_byte,
  input wire [CW-1:0] cnt_word,
  input wire [CW-1:0] cnt_internal,
  input wire [SW-1:0] cost_branch,
  input wire [SW-1:0] cost_stack,
  input wire [SW-1:0] cost_word,
  input wire          byte_to_peri,
  input wire          peri_slow,
  input wire [SW-1:0] cost_byte_mem,
  input wire          dec_valid,
  input wire [4:0]    op_code,
  input wire          op_illegal,
  input wire [3:0]    reg_field,
  input wire [7:0]    abs_addr,
  input wire          uses_reg,
  input wire          uses_abs,
  input wire [TW-1:0] exec_states
);
  wire [19:0]   hd = instr_code[31:12];
  wire [3:0]    fhn = instr_code[7:4];
  wire [SW-1:0] sl = byte_to_peri ? (peri_slow ? 3 : 2) : cost_byte_mem;
  wire [TW-1:0] sum = cnt_fetch * 2 + cnt_branch * cost_branch
    + cnt_stack * cost_stack + cnt_byte * sl + cnt_word * cost_word
    + cnt_internal;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_answer_next: assert property (instr_valid |=> dec_valid)
    else $error("answer missing");
  a_no_spurious: assert property (!instr_valid |=> !dec_valid)
    else $error("spurious answer");
  a_mul_pick: assert property (instr_valid && hd == 20'h01c05 &&
    (fhn == 4'h0 || fhn == 4'h2) |=> op_code == 5'h01) else $error("mul");
  a_div_pick: assert property (instr_valid && hd == 20'h01d05 &&
    (fhn == 4'h1 || fhn == 4'h3) |=> op_code == 5'h02) else $error("div");
  a_muldiv_reject: assert property (instr_valid &&
    (hd == 20'h01c05 || hd == 20'h01d05) && fhn[3:2] != 2'b00
    |=> op_illegal) else $error("mul div variant");
  a_ctrl_load: assert property (instr_valid && hd == 20'h01406 &&
    fhn[3] && !fhn[0] |=> op_code == 5'h03) else $error("ctrl load");
  a_word_logic: assert property (instr_valid && hd == 20'h01f06 &&
    fhn >= 4 && fhn <= 6 |=> op_code == {1'b0, $past(fhn)})
    else $error("word logic");
  a_reg_form: assert property (instr_valid &&
    instr_code[31:25] == 7'h3e |=>
    op_illegal || uses_reg && reg_field == $past(instr_code[23:20]))
    else $error("register field");
  a_abs_form: assert property (instr_valid &&
    instr_code[31:25] == 7'h3f |=>
    op_illegal || uses_abs && abs_addr == $past(instr_code[23:16]))
    else $error("address field");
  a_state_sum: assert property (
    instr_valid |=> exec_states == $past(sum)) else $error("state sum");
  a_illegal_flag: assert property (dec_valid |-> op_illegal == !op_code)
    else $error("illegal flag");
  c_mul: cover property (dec_valid && op_code == 5'h01);
  c_store: cover property (dec_valid && op_code == 5'h0f);
  c_bad: cover property (dec_valid && op_illegal);
  c_b2b: cover property (dec_valid [*3]);
endmodule
bind fbd_decode fbd_decode_properties #(.CW(CW), .SW(SW), .TW(TW)) u_props (.*);

// file: verif/four_byte_opcode_decode_timing_bench.sv
`timescale 1ns/1ps
module four_byte_opcode_decode_timing_bench;
  reg         mclk = 0, reset_n = 0, instr_valid = 0;
  reg  [31:0] instr_code = 0, c;
  reg  [7:0]  cnt_fetch = 0, cnt_branch = 0, cnt_stack = 0;
  reg  [7:0]  cnt_byte = 0, cnt_word = 0, cnt_internal = 0;
  reg  [3:0]  cost_branch = 0, cost_stack = 0, cost_word = 0;
  reg  [3:0]  cost_byte_mem = 0, sl;
  reg         byte_to_peri = 0, peri_slow = 0;
  wire        dec_valid, op_illegal, uses_reg, uses_abs;
  wire [4:0]  op_code;
  wire [3:0]  reg_field;
  wire [7:0]  abs_addr;
  wire [11:0] exec_states;
  reg  [31:0] notes [$];
  reg  [31:0] want;
  reg  [31:0] got;
  reg         ur, ua;
  reg  [4:0]  op;
  reg  [11:0] st;
  integer     fail_count = 0, num_checks = 0, i, r;
  always #25 mclk = ~mclk;
  fbd_decode dut (.*);
  function [4:0] ref_op(input [31:0] k);
    reg [3:0] d;
    begin
      d = k[7:4];
      ref_op = 5'h00;
      if (k[31:12] == 20'h01c05 && (d == 0 || d == 2)) ref_op = 5'h01;
      if (k[31:12] == 20'h01d05 && (d == 1 || d == 3)) ref_op = 5'h02;
      if (k[31:12] == 20'h01406 && d[3] && !d[0]) ref_op = 5'h03;
      if (k[31:12] == 20'h01f06 && d >= 4 && d <= 6) ref_op = {1'b0, d};
      if (k[31:26] == 6'h1f && k[15:13] == 3 && (k[25] || k[19:16] == 0))
      begin
        if (!k[24] && (k[12] ? d >= 3 && d <= 7 : d == 3)) ref_op = d + 4;
        if (k[24] && d <= 2) ref_op = d + 12;
        if (k[24] && !k[12] && d == 7) ref_op = 5'h0f;
      end
    end
  endfunction
  task note;
    begin
      sl = byte_to_peri ? (peri_slow ? 3 : 2) : cost_byte_mem;
      st = cnt_fetch * 2 + cnt_branch * cost_branch + cnt_stack * cost_stack
        + cnt_byte * sl + cnt_word * cost_word + cnt_internal;
      op = ref_op(instr_code);
      ur = instr_code[31:25] == 7'h3e && instr_code[19:16] == 0 &&
        instr_code[15:13] == 3;
      ua = instr_code[31:25] == 7'h3f && instr_code[15:13] == 3;
      if (instr_valid)
        notes.push_back({op, op == 0, ur, ua, ur ? instr_code[23:20] : 4'h0,
          ua ? instr_code[23:16] : 8'h00, st});
    end
  endtask
  task final_report;
    begin
      if (fail_count == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge mclk)
    if (dec_valid === 1'b1)
    begin
      want = notes.size() ? notes.pop_front() : 32'hffffffff;
      got = {op_code, op_illegal, uses_reg, uses_abs, reg_field, abs_addr,
        exec_states};
      num_checks = num_checks + 2;
      if (got[31:12] !== want[31:12])
      begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED decode exp %h got %h", want[31:12], got[31:12]);
      end
      if (got[11:0] !== want[11:0])
      begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED exec_states exp %h got %h", want[11:0],
          got[11:0]);
      end
    end
  initial
  begin
    r = $urandom(32'hb5bb);
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    instr_valid <= 1;
    instr_code <= 32'h7fff7000;
    cnt_fetch <= 2;
    cnt_byte <= 2;
    cost_byte_mem <= 2;
    #1 note;
    for (i = 0; i < 600; i = i + 1)
    begin
      @(posedge mclk);
      r = $urandom % 10;
      c = $urandom;
      if (r < 4)
        c[31:12] = r == 0 ? 20'h01c05 : r == 1 ? 20'h01d05 :
          r == 2 ? 20'h01406 : 20'h01f06;
      else if (r < 8)
      begin
        c[31:24] = 8'h7c + r - 4;
        c[15:13] = 3;
        if (r < 6) c[19:16] = 0;
      end
      instr_code <= c;
      instr_valid <= ($urandom % 4) != 0;
      {cnt_fetch, cnt_branch, cnt_stack} <= $urandom;
      {cnt_byte, cnt_word, cnt_internal} <= $urandom;
      {cost_branch, cost_stack, cost_word, cost_byte_mem} <= $urandom;
      {byte_to_peri, peri_slow} <= $urandom;
      #1 note;
    end
    @(posedge mclk) instr_valid <= 0;
    for (i = 0; i < 10 && notes.size() > 0; i = i + 1) @(posedge mclk);
    if (notes.size() != 0) fail_count = fail_count + 1;
    final_report;
  end
endmodule
